//--- logic/ctu_pkg.sv
// Purpose: shared constants and types for the capture timer unit
// Assumes: registers are reached over a plain byte-wide register port
// Notes:   register indices are local choices; field positions fixed below
package ctu_pkg;

    // register indices on the byte port
    localparam logic [2:0] ADDR_CONTROL   = 3'h0;
    localparam logic [2:0] ADDR_CLK_SEL   = 3'h1;
    localparam logic [2:0] ADDR_CAPCMP    = 3'h2;
    localparam logic [2:0] ADDR_CMP0_LO   = 3'h3;
    localparam logic [2:0] ADDR_CMP0_HI   = 3'h4;
    localparam logic [2:0] ADDR_CMP1_LO   = 3'h5;
    localparam logic [2:0] ADDR_CMP1_HI   = 3'h6;
    localparam logic [2:0] ADDR_EDGE_MODE = 3'h7;

    // timer_control fields
    localparam int CTL_WIDTH_BIT  = 0;
    localparam int CTL_OVF_BIT    = 2;
    localparam int CTL_ENABLE_BIT = 3;
    // capture_compare_control fields
    localparam int CCC_CLR0_BIT   = 0;
    localparam int CCC_CLR1_BIT   = 1;
    localparam int CCC_MODE_BIT   = 2;

    // reset values
    localparam logic [7:0]  RST_CONTROL = 8'h00;
    localparam logic [7:0]  RST_CLK_SEL = 8'h11;
    localparam logic [7:0]  RST_CAPCMP  = 8'h00;
    localparam logic [15:0] RST_CAPTURE = 16'h0000;
    localparam logic [15:0] RST_COUNT   = 16'h0000;

    // count clock select codes, low nibble of count_clock_select
    localparam logic [3:0] SEL_EXT_EDGE = 4'h0;
    localparam int         PRESC_WIDTH  = 11;

    // edge polarity codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef struct packed {
        logic       we;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ctu_wr_t;

    typedef struct packed {
        logic irq_ext;
        logic match0;
        logic match1;
    } ctu_irq_t;

endpackage : ctu_pkg

//--- logic/ctu_edge_detect.sv
// Purpose: synchronise the external input and flag chosen edges
// Assumes: input may be asynchronous to mclk
// Notes:   pulse lasts one mclk cycle
`timescale 1ns/100ps
`default_nettype none
module ctu_edge_detect (
    input  wire logic       mclk,     // system clock
    input  wire logic       reset_n,  // async reset, active low
    input  wire logic       pin,      // raw external input
    input  wire logic [1:0] polarity, // edge_polarity_setting
    output var  logic       edge_hit  // one-cycle valid edge pulse
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic hit;
    } ctu_ed_state_t;

    ctu_ed_state_t st;
    ctu_ed_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.meta = pin;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
        unique case (polarity)
            ctu_pkg::EDGE_FALL: next_st.hit = st.prev & ~st.sync;
            ctu_pkg::EDGE_RISE: next_st.hit = ~st.prev & st.sync;
            ctu_pkg::EDGE_BOTH: next_st.hit = st.prev ^ st.sync;
            default:            next_st.hit = 1'b0;  // edge disabled
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign edge_hit = st.hit;
endmodule : ctu_edge_detect
`default_nettype wire

//--- logic/ctu_timer.sv
// Purpose: capture timer unit with counter, capture, compares, prescaler
// Assumes: byte register port, synchronous to mclk
// Notes:   compare and edge-mode bytes held here to steer matches and the edge detector
`timescale 1ns/100ps
`default_nettype none
module ctu_timer (
    input  wire logic             mclk,            // system clock
    input  wire logic             reset_n,         // async reset, active low
    input  wire ctu_pkg::ctu_wr_t wr,              // register write port
    input  wire logic [2:0]       rd_addr,         // register read index
    input  wire logic             ext_edge_input,  // external pulse input
    output var  logic [7:0]       rd_data,         // register read data
    output var  logic [15:0]      up_counter_wide, // counter value
    output var  logic [15:0]      capture_reg_wide,// capture register
    output var  logic [15:0]      second_cap_cmp_reg_wide, // second register
    output var  ctu_pkg::ctu_irq_t irq,            // one-cycle requests
    output var  logic             rt_trigger,      // real-time output trigger
    output var  logic [3:0]       companion_ctl,   // companion timer control nibble
    output var  logic [3:0]       companion_clk    // companion clock select
);
    typedef struct packed {
        logic [7:0]        timer_control;
        logic [7:0]        count_clock_select;
        logic [7:0]        capture_compare_control;
        logic [1:0]        edge_polarity_setting;
        logic [15:0]       first_compare_reg;
        logic [15:0]       second_cap_cmp_reg;
        logic [15:0]       capture_reg;
        logic [15:0]       up_counter;
        logic [ctu_pkg::PRESC_WIDTH-1:0] presc;
        logic              first_pending;
        logic              clear_pending;
        logic              capt_bump;
        logic              m0_prev;
        logic              m1_prev;
        ctu_pkg::ctu_irq_t irq;
        logic              rt_trigger;
        logic [7:0]        rd_data;
    } ctu_state_t;

    ctu_state_t st;
    ctu_state_t next_st;
    logic       edge_hit;

    ctu_edge_detect u_edge (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .pin      (ext_edge_input),
        .polarity (st.edge_polarity_setting),
        .edge_hit (edge_hit)
    );

    // narrows a value to the active width
    function automatic logic [15:0] fit(input logic [15:0] v, input logic wide);
        fit = wide ? v : {8'h00, v[7:0]};
    endfunction : fit

    // divided clock tick for a select code; code 0 picks edges
    function automatic logic presc_tick(input logic [3:0] sel,
                                        input logic [ctu_pkg::PRESC_WIDTH-1:0] cnt);
        logic [ctu_pkg::PRESC_WIDTH-1:0] mask;
        mask = '0;
        if (sel > 4'h0 && sel < 4'hc) begin
            mask = ctu_pkg::PRESC_WIDTH'((1 << sel) - 1);
        end else begin
            mask = {ctu_pkg::PRESC_WIDTH{1'b1}};
        end
        presc_tick = (cnt & mask) == mask;
    endfunction : presc_tick

    logic        wide;
    logic        enabled;
    logic        cap_mode;
    logic        count_clk;
    logic [15:0] maxval;
    logic [15:0] cnt_next;
    logic        m0;
    logic        m1;

    always_comb begin
        next_st   = st;
        wide      = st.timer_control[ctu_pkg::CTL_WIDTH_BIT];
        enabled   = st.timer_control[ctu_pkg::CTL_ENABLE_BIT];
        cap_mode  = st.capture_compare_control[ctu_pkg::CCC_MODE_BIT];
        maxval    = wide ? 16'hffff : 16'h00ff;
        cnt_next  = st.up_counter;
        next_st.presc = st.presc + 1'b1;
        next_st.irq        = '0;
        next_st.rt_trigger = 1'b0;

        if (st.count_clock_select[3:0] == ctu_pkg::SEL_EXT_EDGE) begin
            count_clk = edge_hit;
        end else begin
            count_clk = presc_tick(st.count_clock_select[3:0], st.presc);
        end

        next_st.irq.irq_ext = edge_hit;

        if (enabled) begin
            if (edge_hit) begin
                next_st.capture_reg = fit(st.up_counter, wide);
                if (cap_mode) begin
                    next_st.second_cap_cmp_reg = fit(st.up_counter, wide);
                    if (st.capture_compare_control[ctu_pkg::CCC_CLR1_BIT]) begin
                        next_st.clear_pending = 1'b1;
                        next_st.capt_bump     = 1'b1;
                    end
                end
            end
            if (count_clk) begin
                if (st.first_pending || st.clear_pending) begin
                    cnt_next = 16'h0000;
                    next_st.first_pending = 1'b0;
                    next_st.clear_pending = 1'b0;
                end else if (fit(st.up_counter, wide) == maxval) begin
                    cnt_next = 16'h0000;
                    next_st.timer_control[ctu_pkg::CTL_OVF_BIT] = 1'b1;
                end else begin
                    cnt_next = fit(st.up_counter + 16'h0001, wide);
                end
            end else if (st.capt_bump) begin
                // momentary N+1 before the pending clear
                cnt_next = fit(st.up_counter + 16'h0001, wide);
                next_st.capt_bump = 1'b0;
            end
            if (count_clk) begin
                next_st.capt_bump = 1'b0;
            end
        end
        next_st.up_counter = cnt_next;

        m0 = enabled && fit(st.up_counter, wide) == fit(st.first_compare_reg, wide);
        m1 = enabled && !cap_mode &&
             fit(st.up_counter, wide) == fit(st.second_cap_cmp_reg, wide);
        next_st.m0_prev = m0;
        next_st.m1_prev = m1;
        next_st.irq.match0 = m0 && !st.m0_prev;
        next_st.irq.match1 = m1 && !st.m1_prev;
        next_st.rt_trigger = m0 && !st.m0_prev;
        if (m0 && !st.m0_prev && st.capture_compare_control[ctu_pkg::CCC_CLR0_BIT]) begin
            next_st.clear_pending = 1'b1;
        end
        if (m1 && !st.m1_prev && st.capture_compare_control[ctu_pkg::CCC_CLR1_BIT]) begin
            next_st.clear_pending = 1'b1;
        end

        if (wr.we) begin
            unique case (wr.addr)
                ctu_pkg::ADDR_CONTROL: begin
                    next_st.timer_control = wr.wdata;
                    // hardware-set overflow wins over a same-cycle clear
                    if (next_st.timer_control[ctu_pkg::CTL_OVF_BIT] == 1'b0 &&
                        enabled && count_clk && !st.first_pending && !st.clear_pending &&
                        fit(st.up_counter, wide) == maxval) begin
                        next_st.timer_control[ctu_pkg::CTL_OVF_BIT] = 1'b1;
                    end
                    if (wr.wdata[ctu_pkg::CTL_ENABLE_BIT] && !enabled) begin
                        next_st.first_pending = 1'b1;
                    end
                    if (!wr.wdata[ctu_pkg::CTL_ENABLE_BIT]) begin
                        next_st.up_counter    = ctu_pkg::RST_COUNT;
                        next_st.first_pending = 1'b0;
                        next_st.clear_pending = 1'b0;
                        next_st.capt_bump     = 1'b0;
                        next_st.irq.match0    = 1'b0;
                        next_st.irq.match1    = 1'b0;
                        next_st.rt_trigger    = 1'b0;
                    end
                    // enable already set: counter and pending state untouched
                end
                ctu_pkg::ADDR_CLK_SEL:   next_st.count_clock_select = wr.wdata;
                ctu_pkg::ADDR_CAPCMP:    next_st.capture_compare_control = wr.wdata;
                ctu_pkg::ADDR_CMP0_LO:   next_st.first_compare_reg[7:0] = wr.wdata;
                ctu_pkg::ADDR_CMP0_HI:   next_st.first_compare_reg[15:8] = wr.wdata;
                ctu_pkg::ADDR_CMP1_LO:   next_st.second_cap_cmp_reg[7:0] = wr.wdata;
                ctu_pkg::ADDR_CMP1_HI:   next_st.second_cap_cmp_reg[15:8] = wr.wdata;
                ctu_pkg::ADDR_EDGE_MODE: next_st.edge_polarity_setting = wr.wdata[1:0];
            endcase
        end

        unique case (rd_addr)
            ctu_pkg::ADDR_CONTROL:   next_st.rd_data = st.timer_control;
            ctu_pkg::ADDR_CLK_SEL:   next_st.rd_data = st.count_clock_select;
            ctu_pkg::ADDR_CAPCMP:    next_st.rd_data = st.capture_compare_control;
            ctu_pkg::ADDR_CMP0_LO:   next_st.rd_data = st.first_compare_reg[7:0];
            ctu_pkg::ADDR_CMP0_HI:   next_st.rd_data = st.first_compare_reg[15:8];
            ctu_pkg::ADDR_CMP1_LO:   next_st.rd_data = st.second_cap_cmp_reg[7:0];
            ctu_pkg::ADDR_CMP1_HI:   next_st.rd_data = st.second_cap_cmp_reg[15:8];
            ctu_pkg::ADDR_EDGE_MODE: next_st.rd_data = {6'h00, st.edge_polarity_setting};
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st                         <= '0;
            st.timer_control           <= ctu_pkg::RST_CONTROL;
            st.count_clock_select      <= ctu_pkg::RST_CLK_SEL;
            st.capture_compare_control <= ctu_pkg::RST_CAPCMP;
            st.capture_reg             <= ctu_pkg::RST_CAPTURE;
            st.up_counter              <= ctu_pkg::RST_COUNT;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data                 = st.rd_data;
    assign up_counter_wide         = st.up_counter;
    assign capture_reg_wide        = st.capture_reg;
    assign second_cap_cmp_reg_wide = st.second_cap_cmp_reg;
    assign irq                     = st.irq;
    assign rt_trigger              = st.rt_trigger;
    assign companion_ctl           = st.timer_control[7:4];
    assign companion_clk           = st.count_clock_select[7:4];
endmodule : ctu_timer
`default_nettype wire

//--- bench/ctu_timer_monitor.sv
// Purpose: port-level checks on the capture timer unit
// Assumes: one mclk domain, async active-low reset
// Notes:   bound to ctu_timer below
`timescale 1ns/100ps
`default_nettype none
module ctu_timer_monitor (
    input wire logic              mclk,             // system clock
    input wire logic              reset_n,          // async reset, active low
    input wire ctu_pkg::ctu_wr_t  wr,               // register write port
    input wire logic [15:0]       up_counter_wide,  // counter value
    input wire logic [15:0]       capture_reg_wide, // capture register
    input wire ctu_pkg::ctu_irq_t irq,              // request pulses
    input wire logic              rt_trigger,       // real-time trigger
    input wire logic [3:0]        companion_ctl,    // companion control
    input wire logic [3:0]        companion_clk     // companion clock select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_ctl_wr;
        wr.we && wr.addr == ctu_pkg::ADDR_CONTROL;
    endsequence
    sequence s_stop_wr;
        s_ctl_wr ##0 !wr.wdata[ctu_pkg::CTL_ENABLE_BIT];
    endsequence
    chk_cap_on_edge: assert property ($changed(capture_reg_wide) |-> irq.irq_ext)
        else $error("capture moved without a valid edge");
    chk_ext_single: assert property (irq.irq_ext |=> !irq.irq_ext)
        else $error("edge request longer than one cycle");
    chk_m0_single: assert property (irq.match0 |=> !irq.match0)
        else $error("first match request longer than one cycle");
    chk_m1_single: assert property ($rose(irq.match1) |=> $fell(irq.match1))
        else $error("second match request longer than one cycle");
    chk_rt_with_m0: assert property (rt_trigger == irq.match0)
        else $error("trigger not aligned with first match");
    chk_stop_zero: assert property (s_stop_wr |=> ##[0:1] up_counter_wide == 16'h0000)
        else $error("counter not zeroed on stop");
    chk_count_step: assert property ($changed(up_counter_wide) |->
        up_counter_wide == 16'h0000 || up_counter_wide == $past(up_counter_wide) + 16'h0001)
        else $error("counter moved other than by one or to zero");
    chk_comp_ctl: assert property (s_ctl_wr |=> companion_ctl == $past(wr.wdata[7:4]))
        else $error("companion control nibble wrong");
    chk_comp_clk: assert property (wr.we && wr.addr == ctu_pkg::ADDR_CLK_SEL |=>
        companion_clk == $past(wr.wdata[7:4])) else $error("companion clock nibble wrong");
endmodule : ctu_timer_monitor
bind ctu_timer ctu_timer_monitor chk_i (.mclk(mclk), .reset_n(reset_n), .wr(wr),
    .up_counter_wide(up_counter_wide), .capture_reg_wide(capture_reg_wide), .irq(irq),
    .rt_trigger(rt_trigger), .companion_ctl(companion_ctl), .companion_clk(companion_clk));
`default_nettype wire

//--- bench/ctu_pulse_src.sv
// Purpose: external pulse source on the edge input
// Assumes: pin is actively driven at all times
// Notes:   one high pulse of hi_len cycles per fire
`timescale 1ns/100ps
`default_nettype none
module ctu_pulse_src (
    input  wire logic       mclk,   // system clock
    input  wire logic       fire,   // start one pulse
    input  wire logic [3:0] hi_len, // high time in cycles
    output var  logic       pin     // drives the edge input
);
    logic [3:0] left;
    initial left = 4'h0;
    always @(posedge mclk) begin
        if (fire)
            left <= hi_len;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    assign pin = (left != 4'h0);
endmodule : ctu_pulse_src
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: self-checking bench for the capture timer unit
// Assumes: register port timing as handed over
// Notes:   edge-count mode gives exact expected counts
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic mclk, reset_n, ext_pin, rt_trigger, fire;
    ctu_pkg::ctu_wr_t  wr;
    ctu_pkg::ctu_irq_t irq;
    logic [2:0]  rd_addr;
    logic [7:0]  rd_data, cval;
    logic [15:0] cnt, cap, cap2, mx;
    logic [3:0]  comp_ctl, comp_clk, hi_len;
    logic [31:0] seed;
    int          miscompares, n_checks, n_ext, n_m0;
    ctu_timer DUT (.mclk(mclk), .reset_n(reset_n), .wr(wr), .rd_addr(rd_addr),
        .ext_edge_input(ext_pin), .rd_data(rd_data), .up_counter_wide(cnt),
        .capture_reg_wide(cap), .second_cap_cmp_reg_wide(cap2), .irq(irq),
        .rt_trigger(rt_trigger), .companion_ctl(comp_ctl), .companion_clk(comp_clk));
    ctu_pulse_src src (.mclk(mclk), .fire(fire), .hi_len(hi_len), .pin(ext_pin));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (irq.irq_ext === 1'b1) n_ext <= n_ext + 1;
        if (irq.match0 === 1'b1) n_m0 <= n_m0 + 1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // value seen after k edges, lag edges behind
    function automatic logic [15:0] exp_val(input int k, input int lag);
        return (k > lag) ? 16'(k - lag) : 16'h0000;
    endfunction : exp_val
    task automatic test_done();
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 wr = '{we: 1'b1, addr: a, wdata: d};
        @(posedge mclk);
        #1 wr.we = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        #1 rd_addr = a;
        @(posedge mclk);
        #1 check({8'h00, rd_data}, {8'h00, exp});
    endtask : rd_chk
    task automatic pulse();
        seed = lfsr(seed);
        @(posedge mclk);
        #1 fire = 1'b1;
        hi_len = 4'h3 + {1'b0, seed[2:0]};
        @(posedge mclk);
        #1 fire = 1'b0;
        repeat (30) @(posedge mclk);
        #1;
    endtask : pulse
    // sel 0: counter equals v, 1: first match, 2: second match
    task automatic wait_for(input int sel, input logic [15:0] v);
        int i;
        for (i = 0; i < 1000; i++) begin
            @(posedge mclk);
            #1;
            if ((sel == 0 && cnt === v) || (sel == 1 && irq.match0 === 1'b1)
                || (sel == 2 && irq.match1 === 1'b1)) break;
        end
        if (i == 1000) begin
            miscompares++;
            $display("Error at %0t: wait ran out", $time);
            test_done();
        end
    endtask : wait_for
    initial begin
        wr = '0;
        rd_addr = 3'h0;
        fire = 1'b0;
        hi_len = 4'h4;
        seed = 32'h5795;
        miscompares = 0;
        n_checks = 0;
        n_ext = 0;
        n_m0 = 0;
        reset_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        rd_chk(ctu_pkg::ADDR_CONTROL, ctu_pkg::RST_CONTROL);
        rd_chk(ctu_pkg::ADDR_CLK_SEL, ctu_pkg::RST_CLK_SEL);
        rd_chk(ctu_pkg::ADDR_CAPCMP, ctu_pkg::RST_CAPCMP);
        check(cap, ctu_pkg::RST_CAPTURE);
        check(cnt, ctu_pkg::RST_COUNT);
        seed = lfsr(seed);
        wr_reg(ctu_pkg::ADDR_CONTROL, {seed[7:4], 4'h0});
        check({12'h000, comp_ctl}, {12'h000, seed[7:4]});
        wr_reg(ctu_pkg::ADDR_CLK_SEL, 8'h10);
        for (int p = 0; p < 4; p++) begin
            wr_reg(ctu_pkg::ADDR_EDGE_MODE, 8'(p));
            n_ext = 0;
            pulse();
            check(16'(n_ext), (p == 3) ? 16'h0002 : (p == 2) ? 16'h0000 : 16'h0001);
        end
        check(cap, 16'h0000);
        wr_reg(ctu_pkg::ADDR_EDGE_MODE, {6'h00, ctu_pkg::EDGE_RISE});
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h08);
        for (int k = 1; k <= 4; k++) begin
            pulse();
            check(cnt, exp_val(k, 1));
            check(cap, exp_val(k, 2));
        end
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h08);
        check(cnt, 16'h0003);
        pulse();
        check(cnt, 16'h0004);
        wr_reg(ctu_pkg::ADDR_CAPCMP, 8'h06);
        wr_reg(ctu_pkg::ADDR_CMP0_LO, 8'h05);
        wr_reg(ctu_pkg::ADDR_CMP0_HI, 8'h00);
        n_m0 = 0;
        pulse();
        check(cap2, 16'h0004);
        check(16'(n_m0), 16'h0001);
        check(cnt, 16'h0005);
        pulse();
        check(cnt, 16'h0000);
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h00);
        pulse();
        check(cap, 16'h0005);
        wr_reg(ctu_pkg::ADDR_CAPCMP, 8'h01);
        wr_reg(ctu_pkg::ADDR_CLK_SEL, 8'h11);
        for (int j = 0; j < 3; j++) begin
            seed = lfsr(seed);
            cval = 8'h10 + {1'b0, seed[6:0]};
            wr_reg(ctu_pkg::ADDR_CMP0_LO, cval);
            wr_reg(ctu_pkg::ADDR_CONTROL, 8'h08);
            wait_for(1, 16'h0000);
            mx = 16'h0000;
            repeat (600) begin
                @(posedge mclk);
                #1;
                if (cnt > mx) mx = cnt;
            end
            check(mx, {8'h00, cval});
            wr_reg(ctu_pkg::ADDR_CONTROL, 8'h00);
        end
        wr_reg(ctu_pkg::ADDR_CAPCMP, 8'h00);
        wr_reg(ctu_pkg::ADDR_CMP1_LO, 8'h30);
        wr_reg(ctu_pkg::ADDR_CMP1_HI, 8'h00);
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h08);
        wait_for(2, 16'h0000);
        wait_for(0, 16'h00ff);
        wait_for(0, 16'h0000);
        rd_chk(ctu_pkg::ADDR_CONTROL, 8'h0c);
        wait_for(0, 16'h0040);
        rd_chk(ctu_pkg::ADDR_CONTROL, 8'h0c);
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h08);
        rd_chk(ctu_pkg::ADDR_CONTROL, 8'h08);
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h00);
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h09);
        wait_for(0, 16'h0100);
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h00);
        wr_reg(ctu_pkg::ADDR_CAPCMP, 8'h06);
        wr_reg(ctu_pkg::ADDR_CMP0_LO, 8'h06);
        wr_reg(ctu_pkg::ADDR_CLK_SEL, 8'h16);
        wr_reg(ctu_pkg::ADDR_CONTROL, 8'h08);
        // capture at 5 with compare at 6 still raises a match
        wait_for(0, 16'h0005);
        n_m0 = 0;
        pulse();
        check(cap2, 16'h0005);
        check(16'(n_m0), 16'h0001);
        check(cnt, 16'h0006);
        wait_for(0, 16'h0000);
        reset_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        check(cap, ctu_pkg::RST_CAPTURE);
        repeat (40) @(posedge mclk);
        #1 check(cnt, ctu_pkg::RST_COUNT);
        rd_chk(ctu_pkg::ADDR_CONTROL, ctu_pkg::RST_CONTROL);
        rd_chk(ctu_pkg::ADDR_CLK_SEL, ctu_pkg::RST_CLK_SEL);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
